// *** src/sdtas_pkg.sv ***
package sdtas_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] PRESENT_OFF = 8'h24;
  localparam logic [ADDR_W-1:0] INT_STATUS_OFF = 8'h30;
  localparam logic [ADDR_W-1:0] INT_CLEAR_OFF = 8'h34;
  localparam logic [ADDR_W-1:0] INT_ENABLE_OFF = 8'h38;
  localparam int TX_WOK_BIT = 10;
  localparam int RD_ACT_BIT = 9;
  localparam int WR_ACT_BIT = 8;
  localparam int DAT_ACT_BIT = 2;
  localparam int INHIBIT_BIT = 1;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_GAP_BIT = 1;
  localparam int INT_W = 2;
  localparam logic [INT_W-1:0] INT_EN_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sdtas_pkg

// *** src/sdtas_irq.sv ***
`timescale 1ns/1ps
module sdtas_irq
  import sdtas_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sdtas_pkg::INT_W-1:0] event_set,
  input wire logic clear_we,
  input wire logic enable_we,
  input wire logic [sdtas_pkg::INT_W-1:0] wr_bits,
  output logic [sdtas_pkg::INT_W-1:0] status,
  output logic [sdtas_pkg::INT_W-1:0] enable,
  output logic irq
);
  typedef struct packed {
    logic [INT_W-1:0] status;
    logic [INT_W-1:0] enable;
    logic irq;
  } sdtas_irq_t;

  sdtas_irq_t irq_reg;
  sdtas_irq_t irq_next;

  always_comb begin
    irq_next = irq_reg;
    // a new event in the clearing cycle survives the clear
    if (clear_we) begin
      irq_next.status = irq_reg.status & ~wr_bits;
    end
    irq_next.status = irq_next.status | event_set;
    if (enable_we) begin
      irq_next.enable = wr_bits;
    end
    irq_next.irq = |(irq_next.status & irq_next.enable);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= '{status: '0, enable: INT_EN_RST, irq: 1'b0};
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign status = irq_reg.status;
  assign enable = irq_reg.enable;
  assign irq = irq_reg.irq;
endmodule : sdtas_irq

// *** src/sdtas_top.sv ***
`timescale 1ns/1ps
module sdtas_top
  import sdtas_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [sdtas_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [sdtas_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sdtas_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [sdtas_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transfer engine events, same clock
  input wire logic rd_cmd_end,
  input wire logic wr_cmd_end,
  input wire logic cont_req,
  input wire logic gap_stop_request,
  input wire logic rd_all_done,
  input wire logic rd_valid_done,
  input wire logic rd_last_end_bit,
  input wire logic rd_gap_halt,
  input wire logic wr_crc_status,
  input wire logic wr_last_block,
  input wire logic tx_all_written,
  input wire logic tx_buf_full,
  // status out
  output logic read_transfer_active,
  output logic write_transfer_active,
  output logic data_line_active,
  output logic tx_write_ok,
  output logic cmd_inhibit_dat,
  output logic irq
);
  typedef struct packed {
    logic rd_act;
    logic wr_act;
    logic dat_act;
    logic tx_wok;
    logic dir_wr;
    logic inhibit;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [DATA_W-1:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
  } sdtas_state_t;

  sdtas_state_t st_reg;
  sdtas_state_t st_next;

  logic [INT_W-1:0] int_status_w;
  logic [INT_W-1:0] int_en_w;
  logic [INT_W-1:0] event_w;
  logic clear_we_w;
  logic enable_we_w;
  logic rd_set;
  logic rd_clr;
  logic wr_set;
  logic wr_clr;
  logic dat_set;
  logic dat_clr;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    is_mapped = (addr == PRESENT_OFF) || (addr == INT_STATUS_OFF) ||
                (addr == INT_CLEAR_OFF) || (addr == INT_ENABLE_OFF);
  endfunction : is_mapped

  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] addr,
                                                  input sdtas_state_t s,
                                                  input logic [INT_W-1:0] sts,
                                                  input logic [INT_W-1:0] en);
    logic [DATA_W-1:0] v;
    v = '0;
    case (addr)
      PRESENT_OFF: begin
        v[TX_WOK_BIT] = s.tx_wok;
        v[RD_ACT_BIT] = s.rd_act;
        v[WR_ACT_BIT] = s.wr_act;
        v[DAT_ACT_BIT] = s.dat_act;
        v[INHIBIT_BIT] = s.inhibit;
      end
      INT_STATUS_OFF: v[INT_W-1:0] = sts;
      INT_ENABLE_OFF: v[INT_W-1:0] = en;
      default: v = '0;
    endcase
    read_word = v;
  endfunction : read_word

  always_comb begin
    st_next = st_reg;
    // activity flags; a set wins over a clear in the same cycle
    rd_set = rd_cmd_end || (cont_req && !st_reg.dir_wr);
    rd_clr = rd_all_done || (gap_stop_request && rd_valid_done);
    wr_set = wr_cmd_end || (cont_req && st_reg.dir_wr);
    wr_clr = wr_crc_status && (wr_last_block || gap_stop_request);
    dat_set = rd_cmd_end || wr_cmd_end || cont_req;
    if (st_reg.dir_wr) begin
      dat_clr = wr_clr;
    end else begin
      dat_clr = rd_last_end_bit || (gap_stop_request && rd_gap_halt);
    end
    if (rd_set) begin
      st_next.rd_act = 1'b1;
    end else if (rd_clr) begin
      st_next.rd_act = 1'b0;
    end
    if (wr_set) begin
      st_next.wr_act = 1'b1;
    end else if (wr_clr) begin
      st_next.wr_act = 1'b0;
    end
    if (dat_set) begin
      st_next.dat_act = 1'b1;
    end else if (dat_clr) begin
      st_next.dat_act = 1'b0;
    end
    if (wr_cmd_end) begin
      st_next.dir_wr = 1'b1;
    end else if (rd_cmd_end) begin
      st_next.dir_wr = 1'b0;
    end
    if (tx_all_written) begin
      st_next.tx_wok = 1'b1;
    end else if (tx_buf_full) begin
      st_next.tx_wok = 1'b0;
    end
    st_next.inhibit = st_next.dat_act || st_next.rd_act;

    // interrupt events on falling flags
    event_w = '0;
    event_w[INT_DONE_BIT] = (st_reg.rd_act && !st_next.rd_act) ||
                            (st_reg.dir_wr && st_reg.dat_act && !st_next.dat_act);
    event_w[INT_GAP_BIT] = !st_reg.dir_wr && gap_stop_request &&
                           st_reg.dat_act && !st_next.dat_act;

    // write channel: address and data taken in either order
    clear_we_w = 1'b0;
    enable_we_w = 1'b0;
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_lane0 = s_axi_wstrb[0];
    end
    if (st_next.aw_have && st_next.w_have && !st_reg.bvalid) begin
      st_next.bvalid = 1'b1;
      st_next.bresp = is_mapped(st_next.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      clear_we_w = (st_next.aw_addr == INT_CLEAR_OFF) && st_next.w_lane0;
      enable_we_w = (st_next.aw_addr == INT_ENABLE_OFF) && st_next.w_lane0;
    end else if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    st_next.awready = !st_next.aw_have && !st_next.bvalid;
    st_next.wready = !st_next.w_have && !st_next.bvalid;

    // read channel: one cycle from address to data
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      st_next.rdata = read_word(s_axi_araddr, st_reg, int_status_w, int_en_w);
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    st_next.arready = !st_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  sdtas_irq u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_set(event_w),
    .clear_we(clear_we_w),
    .enable_we(enable_we_w),
    .wr_bits(st_next.w_data[INT_W-1:0]),
    .status(int_status_w),
    .enable(int_en_w),
    .irq(irq)
  );

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;
  assign read_transfer_active = st_reg.rd_act;
  assign write_transfer_active = st_reg.wr_act;
  assign data_line_active = st_reg.dat_act;
  assign tx_write_ok = st_reg.tx_wok;
  assign cmd_inhibit_dat = st_reg.inhibit;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // a fall caused by reset is no transfer end, so the event checks skip that edge
  tx_ok_set_a: assert property (tx_all_written |=> tx_write_ok)
    else $error("write-ok flag not raised");
  tx_ok_clr_a: assert property (tx_buf_full && !tx_all_written |=> !tx_write_ok)
    else $error("write-ok flag not dropped");
  rd_act_set_a: assert property (rd_cmd_end |=> read_transfer_active)
    else $error("read active not set");
  rd_cont_a: assert property (cont_req && !st_reg.dir_wr |=> read_transfer_active)
    else $error("read active not restarted");
  rd_act_clr_a: assert property (rd_all_done && !rd_cmd_end && !cont_req
      |=> !read_transfer_active)
    else $error("read active not cleared");
  rd_done_irq_a: assert property ($fell(read_transfer_active) && $past(aresetn)
      |-> int_status_w[INT_DONE_BIT])
    else $error("no done event on read fall");
  wr_act_set_a: assert property (wr_cmd_end |=> write_transfer_active)
    else $error("write active not set");
  wr_cont_a: assert property (cont_req && st_reg.dir_wr |=> write_transfer_active)
    else $error("write active not restarted");
  wr_act_clr_a: assert property (wr_crc_status && wr_last_block
      && !wr_cmd_end && !cont_req |=> !write_transfer_active)
    else $error("write active not cleared");
  gap_evt_a: assert property ($fell(data_line_active) && $past(aresetn)
      && !$past(st_reg.dir_wr) && $past(gap_stop_request) |-> int_status_w[INT_GAP_BIT])
    else $error("no gap event");
  rd_dat_a: assert property (rd_cmd_end ##1 (!data_line_active) |-> 1'b0)
    else $error("data line not set on read");
  rd_dat_clr_a: assert property (!st_reg.dir_wr && rd_last_end_bit
      && !rd_cmd_end && !wr_cmd_end && !cont_req |=> !data_line_active)
    else $error("data line not cleared on read");
  wr_done_irq_a: assert property ($fell(data_line_active) && $past(aresetn)
      && $past(st_reg.dir_wr) |-> int_status_w[INT_DONE_BIT])
    else $error("no done event on write fall");
  inhibit_a: assert property (cmd_inhibit_dat ==
      (data_line_active || read_transfer_active))
    else $error("hold flag mismatch");
  wr_dat_a: assert property (wr_cmd_end |=> data_line_active ##0 st_reg.dir_wr)
    else $error("data line not set on write");
  irq_lvl_a: assert property (irq == |(int_status_w & int_en_w))
    else $error("irq level mismatch");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during data");

  rd_full_c: cover property (rd_cmd_end ##[1:50] $fell(read_transfer_active));
  gap_stop_c: cover property (gap_stop_request && int_status_w[INT_GAP_BIT]);
  wr_full_c: cover property (wr_cmd_end ##[1:50] $fell(write_transfer_active));
  wr_cont_c: cover property (cont_req && st_reg.dir_wr);
  irq_c: cover property ($rose(irq));
endmodule : sdtas_top

// *** tb/sdtas_card_model.sv ***
`timescale 1ns/1ps
module sdtas_card_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic [3:0] ev,
  output logic [9:0] pulse
);
  // one-cycle strobe per bus event, silent between events
  always_ff @(posedge aclk) begin
    if (!aresetn) pulse <= 10'h000;
    else pulse <= go ? (10'h001 << ev) : 10'h000;
  end
endmodule : sdtas_card_model

// *** tb/sdtas_test.sv ***
`timescale 1ns/1ps
module sdtas_test;
  import sdtas_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic go = 0, gap = 0, last = 0;
  logic [3:0] ev = '0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, rd_act, wr_act, dat_act, tx_ok, hold, irq;
  logic [1:0] bresp, rresp;
  logic [DATA_W-1:0] rdata;
  logic [9:0] pulse;
  int fail_count = 0, compares = 0;

  sdtas_card_model card_u (.aclk(aclk), .aresetn(aresetn), .go(go), .ev(ev), .pulse(pulse));

  sdtas_top dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rd_cmd_end(pulse[0]), .wr_cmd_end(pulse[1]), .cont_req(pulse[2]),
    .gap_stop_request(gap), .rd_all_done(pulse[3]), .rd_valid_done(pulse[4]),
    .rd_last_end_bit(pulse[5]), .rd_gap_halt(pulse[6]), .wr_crc_status(pulse[7]),
    .wr_last_block(last), .tx_all_written(pulse[8]), .tx_buf_full(pulse[9]),
    .read_transfer_active(rd_act), .write_transfer_active(wr_act),
    .data_line_active(dat_act), .tx_write_ok(tx_ok), .cmd_inhibit_dat(hold), .irq(irq));

  initial begin
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // flags packed as tx_ok, rd_act, wr_act, dat_act, hold
  task automatic flg(input logic [4:0] e);
    chk({tx_ok, rd_act, wr_act, dat_act, hold}, e);
  endtask : flg

  // waits for the answer however long it takes; only the watchdog ends a hang
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, er);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(rresp, er);
  endtask : axi_rd

  // 0 rd end, 1 wr end, 2 continue, 3 all done, 4 valid done, 5 last end bit,
  // 6 gap halt, 7 crc status, 8 all written, 9 buffer full
  task automatic evt(input int k);
    @(posedge aclk);
    go <= 1;
    ev <= k[3:0];
    @(posedge aclk);
    go <= 0;
    repeat (3) @(posedge aclk);
  endtask : evt

  task automatic clr(input logic [31:0] st);
    axi_rd(INT_STATUS_OFF, st, RESP_OKAY);
    axi_wr(INT_CLEAR_OFF, 32'h3, RESP_OKAY);
    axi_rd(INT_STATUS_OFF, 32'h0, RESP_OKAY);
  endtask : clr

  initial begin
    #1000000;
    fail_count++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    flg(5'h00);
    axi_rd(INT_ENABLE_OFF, 32'h0, RESP_OKAY);
    axi_wr(INT_ENABLE_OFF, 32'h3, RESP_OKAY);
    evt(0);
    flg(5'h0B);
    axi_rd(PRESENT_OFF, 32'h0000_0206, RESP_OKAY);
    evt(5);
    flg(5'h09);
    evt(3);
    flg(5'h00);
    chk(irq, 1'b1);
    clr(32'h1);
    chk(irq, 1'b0);
    @(posedge aclk) gap <= 1;
    evt(0);
    evt(6);
    flg(5'h09);
    axi_rd(INT_STATUS_OFF, 32'h2, RESP_OKAY);
    evt(4);
    flg(5'h00);
    clr(32'h3);
    evt(2);
    flg(5'h0B);
    @(posedge aclk) gap <= 0;
    evt(5);
    evt(3);
    clr(32'h1);
    evt(1);
    flg(5'h07);
    axi_rd(PRESENT_OFF, 32'h0000_0106, RESP_OKAY);
    evt(7);
    flg(5'h07);
    @(posedge aclk) last <= 1;
    evt(7);
    flg(5'h00);
    clr(32'h1);
    @(posedge aclk) last <= 0;
    gap <= 1;
    evt(1);
    evt(7);
    flg(5'h00);
    axi_wr(INT_CLEAR_OFF, 32'h3, RESP_OKAY);
    @(posedge aclk) gap <= 0;
    evt(2);
    flg(5'h07);
    @(posedge aclk) last <= 1;
    evt(7);
    clr(32'h1);
    // write-ok set and drop are judged here with no stop request pending
    evt(8);
    flg(5'h10);
    evt(9);
    flg(5'h00);
    axi_wr(INT_ENABLE_OFF, 32'h0, RESP_OKAY);
    evt(0);
    evt(3);
    chk(irq, 1'b0);
    axi_wr(INT_ENABLE_OFF, 32'h1, RESP_OKAY);
    axi_rd(INT_STATUS_OFF, 32'h1, RESP_OKAY);
    chk(irq, 1'b1);
    clr(32'h1);
    // a write without byte lane 0 is answered but leaves the register alone
    wstrb <= 4'hE;
    axi_wr(INT_ENABLE_OFF, 32'h0, RESP_OKAY);
    wstrb <= 4'hF;
    axi_rd(INT_ENABLE_OFF, 32'h1, RESP_OKAY);
    axi_rd(8'h3C, 32'h0, RESP_SLVERR);
    axi_wr(8'h3C, 32'h3, RESP_SLVERR);
    evt(1);
    @(posedge aclk) aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    flg(5'h00);
    axi_rd(INT_ENABLE_OFF, 32'h0, RESP_OKAY);
    conclude();
  end
endmodule : sdtas_test
